// ---- rtl/tenbase_ops_pkg.sv ----
// Package with register map, field positions and timing constants for the 10 Mb/s operations block
package tenbase_ops_pkg;

    // =========================================================================
    // Register map (printed offsets are register indices)
    // =========================================================================
    localparam logic [4:0] IDX_TEN_MEG_OPS = 5'h12;
    localparam logic [4:0] IDX_EXT_STATUS_MIRROR = 5'h11;
    localparam logic [4:0] IDX_IRQ_STATUS = 5'h1A;
    localparam logic [4:0] IDX_IRQ_ENABLE = 5'h1B;
    localparam logic [4:0] IDX_IRQ_CLEAR = 5'h1C;

    // =========================================================================
    // Operations register fields
    // =========================================================================
    localparam int OPS_REMOTE_JABBER = 15;
    localparam int OPS_POL_REVERSED = 14;
    localparam int OPS_RSVD_HI = 13;
    localparam int OPS_RSVD_LO = 6;
    localparam int OPS_JABBER_INH = 5;
    localparam int OPS_RSVD_ONE = 4;
    localparam int OPS_AUTOPOL_INH = 3;
    localparam int OPS_SQE_INH = 2;
    localparam int OPS_LINKLOSS_INH = 1;
    localparam int OPS_SQUELCH_INH = 0;
    localparam logic [15:0] OPS_RESET = 16'h0010;
    localparam logic [15:0] OPS_WR_MASK = 16'h3FFF;

    // Mirror register fields
    localparam int MIR_JABBER = 2;
    localparam int MIR_REMOTE_FAULT = 1;
    localparam int MIR_LINK = 0;

    // Interrupt bits
    localparam int IRQ_REMOTE_JABBER = 0;
    localparam int IRQ_POL_REVERSED = 1;
    localparam int IRQ_W = 2;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int SQE_DELAY_NS = 1000;
    localparam int SQE_WIDTH_NS = 1000;
    localparam int SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SQE_WIDTH_CYC = SQE_WIDTH_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SQE_DELAY_CNT = 8'(SQE_DELAY_CYC);
    localparam logic [7:0] SQE_WIDTH_CNT = 8'(SQE_WIDTH_CYC);

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [2:0] {
        SQE_IDLE = 3'b001,
        SQE_WAIT = 3'b010,
        SQE_PULSE = 3'b100
    } sqe_state_t;

    typedef struct packed {
        logic jabber_inh;
        logic autopol_inh;
        logic sqe_inh;
        logic linkloss_inh;
        logic squelch_inh;
    } ops_ctrl_t;

    typedef struct packed {
        logic jabber;
        logic remote_fault;
        logic link;
    } basic_status_t;

endpackage

// ---- rtl/tenbase_t_operations_register.sv ----
// 10 Mb/s twisted-pair operations register, mirror status and SQE test logic
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] Register read or port reset clears remote jabber
// [R2] Receive jabber sets flag, informational only
// [R3] Polarity reversal flag latches high, read-only
// [R4] Operation continues unaffected by polarity reversal
// [R5] Software writes defaults into reserved bits
// [R6] Jabber inhibit disables transmit jabber checking
// [R7] Auto-polarity inhibit suppresses polarity correction
// [R8] Auto-polarity inhibit also governs 100 Mb/s
// [R9] SQE inhibit suppresses SQE test generation
// [R10] Collision pulse after transmit enable falls
// [R11] Full duplex or repeater inhibits SQE
// [R12] SQE inhibit bit unchanged by auto-inhibit
// [R13] Link-loss inhibit forces link passed
// [R14] Squelch inhibit demands data then idle
// [R15] Mirror jabber equals basic jabber bit
// [R16] Mirror remote fault equals basic bit
// [R17] Mirror link equals basic link bit
// [R18] Latched bits hold; set beats clear
module tenbase_t_operations_register (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic rx_jabber_i,
    input wire logic rx_pol_reversed_i,
    input wire logic tx_en_i,
    input wire logic full_duplex_i,
    input wire logic repeater_mode_i,
    input wire tenbase_ops_pkg::basic_status_t basic_status_i,
    output tenbase_ops_pkg::ops_ctrl_t ctrl_o,
    output logic jabber_check_en_o,
    output logic pol_correct_en_o,
    output logic link_force_pass_o,
    output logic squelch_need_idle_o,
    output logic sqe_col_o,
    output logic irq_o
);

    // =========================================================================
    // Register state
    // =========================================================================
    logic [15:0] ops_q;
    logic remote_jabber_q;
    logic pol_rev_q;
    logic [tenbase_ops_pkg::IRQ_W-1:0] irq_stat_q;
    logic [tenbase_ops_pkg::IRQ_W-1:0] irq_en_q;
    logic [tenbase_ops_pkg::IRQ_W-1:0] irq_evt;
    logic [tenbase_ops_pkg::IRQ_W-1:0] irq_clr;
    logic ops_wr;
    logic ops_rd;
    logic sqe_allowed;
    logic tx_en_q;
    logic [15:0] rdata_d;
    tenbase_ops_pkg::sqe_state_t sqe_q;
    logic [7:0] sqe_cnt_q;

    assign ops_wr = wr_i && (addr_i == tenbase_ops_pkg::IDX_TEN_MEG_OPS);
    assign ops_rd = rd_i && (addr_i == tenbase_ops_pkg::IDX_TEN_MEG_OPS);

    // =========================================================================
    // Control bits
    // =========================================================================
    // Reserved bits are stored as written; software is expected to keep defaults
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ops_q <= tenbase_ops_pkg::OPS_RESET;
        end else if (ops_wr) begin
            ops_q <= wdata_i & tenbase_ops_pkg::OPS_WR_MASK; // [R5] [R12]
        end
    end

    // =========================================================================
    // Latching-high status
    // =========================================================================
    // New detection wins over the read that clears it, so no event is lost
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            remote_jabber_q <= 1'b0; // [R1]
            pol_rev_q <= 1'b0;
        end else begin
            remote_jabber_q <= rx_jabber_i || (remote_jabber_q && !ops_rd); // [R1] [R2] [R18]
            pol_rev_q <= rx_pol_reversed_i || (pol_rev_q && !ops_rd); // [R3] [R18]
        end
    end

    // =========================================================================
    // Control outputs to the datapath
    // =========================================================================
    // Polarity reversal gates none of these outputs; correction follows only the inhibit bit
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_o <= '0;
            jabber_check_en_o <= 1'b1;
            pol_correct_en_o <= 1'b1;
            link_force_pass_o <= 1'b0;
            squelch_need_idle_o <= 1'b0;
        end else begin
            ctrl_o.jabber_inh <= ops_q[tenbase_ops_pkg::OPS_JABBER_INH];
            ctrl_o.autopol_inh <= ops_q[tenbase_ops_pkg::OPS_AUTOPOL_INH];
            ctrl_o.sqe_inh <= ops_q[tenbase_ops_pkg::OPS_SQE_INH];
            ctrl_o.linkloss_inh <= ops_q[tenbase_ops_pkg::OPS_LINKLOSS_INH];
            ctrl_o.squelch_inh <= ops_q[tenbase_ops_pkg::OPS_SQUELCH_INH];
            jabber_check_en_o <= !ops_q[tenbase_ops_pkg::OPS_JABBER_INH]; // [R6]
            // Applies at both line rates [R8]
            pol_correct_en_o <= !ops_q[tenbase_ops_pkg::OPS_AUTOPOL_INH]; // [R7] [R4]
            link_force_pass_o <= ops_q[tenbase_ops_pkg::OPS_LINKLOSS_INH]; // [R13]
            squelch_need_idle_o <= ops_q[tenbase_ops_pkg::OPS_SQUELCH_INH]; // [R14]
        end
    end

    // =========================================================================
    // SQE test generator
    // =========================================================================
    // Auto-inhibit is applied here only, so the stored control bit keeps its value
    assign sqe_allowed = !ops_q[tenbase_ops_pkg::OPS_SQE_INH]
                         && !full_duplex_i && !repeater_mode_i; // [R9] [R11] [R12]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= tx_en_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sqe_q <= tenbase_ops_pkg::SQE_IDLE;
            sqe_cnt_q <= 8'h00;
            sqe_col_o <= 1'b0;
        end else begin
            case (sqe_q)
                tenbase_ops_pkg::SQE_IDLE: begin
                    sqe_col_o <= 1'b0;
                    if (tx_en_q && !tx_en_i && sqe_allowed) begin
                        sqe_q <= tenbase_ops_pkg::SQE_WAIT; // [R10]
                        sqe_cnt_q <= tenbase_ops_pkg::SQE_DELAY_CNT;
                    end
                end
                tenbase_ops_pkg::SQE_WAIT: begin
                    if (tx_en_i || !sqe_allowed) begin
                        sqe_q <= tenbase_ops_pkg::SQE_IDLE;
                    end else if (sqe_cnt_q <= 8'h01) begin
                        sqe_q <= tenbase_ops_pkg::SQE_PULSE;
                        sqe_cnt_q <= tenbase_ops_pkg::SQE_WIDTH_CNT;
                        sqe_col_o <= 1'b1; // [R10]
                    end else begin
                        sqe_cnt_q <= sqe_cnt_q - 8'h01;
                    end
                end
                tenbase_ops_pkg::SQE_PULSE: begin
                    if (sqe_cnt_q <= 8'h01) begin
                        sqe_q <= tenbase_ops_pkg::SQE_IDLE;
                        sqe_col_o <= 1'b0;
                    end else begin
                        sqe_cnt_q <= sqe_cnt_q - 8'h01;
                    end
                end
                default: begin
                    sqe_q <= tenbase_ops_pkg::SQE_IDLE;
                    sqe_col_o <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================================
    // Interrupts
    // =========================================================================
    assign irq_evt[tenbase_ops_pkg::IRQ_REMOTE_JABBER] = rx_jabber_i;
    assign irq_evt[tenbase_ops_pkg::IRQ_POL_REVERSED] = rx_pol_reversed_i;
    assign irq_clr = (wr_i && addr_i == tenbase_ops_pkg::IDX_IRQ_CLEAR)
                     ? wdata_i[tenbase_ops_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr); // [R18]
            if (wr_i && addr_i == tenbase_ops_pkg::IDX_IRQ_ENABLE) begin
                irq_en_q <= wdata_i[tenbase_ops_pkg::IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    // =========================================================================
    // Read path
    // =========================================================================
    always_comb begin
        rdata_d = 16'h0000;
        case (addr_i)
            tenbase_ops_pkg::IDX_TEN_MEG_OPS: begin
                rdata_d = ops_q;
                rdata_d[tenbase_ops_pkg::OPS_REMOTE_JABBER] = remote_jabber_q;
                rdata_d[tenbase_ops_pkg::OPS_POL_REVERSED] = pol_rev_q;
            end
            tenbase_ops_pkg::IDX_EXT_STATUS_MIRROR: begin
                rdata_d[tenbase_ops_pkg::MIR_JABBER] = basic_status_i.jabber; // [R15]
                rdata_d[tenbase_ops_pkg::MIR_REMOTE_FAULT] = basic_status_i.remote_fault; // [R16]
                rdata_d[tenbase_ops_pkg::MIR_LINK] = basic_status_i.link; // [R17]
            end
            tenbase_ops_pkg::IDX_IRQ_STATUS: begin
                rdata_d[tenbase_ops_pkg::IRQ_W-1:0] = irq_stat_q;
            end
            tenbase_ops_pkg::IDX_IRQ_ENABLE: begin
                rdata_d[tenbase_ops_pkg::IRQ_W-1:0] = irq_en_q;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // Data only in the cycle after the strobe; zero otherwise
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rdata_d : 16'h0000;
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    sequence ops_read_s;
        rd_i && addr_i == tenbase_ops_pkg::IDX_TEN_MEG_OPS && !rx_jabber_i;
    endsequence

    sequence jabber_idle_s;
        !rx_jabber_i;
    endsequence

    property read_clears_p;
        @(posedge clk_i) disable iff (srst_i)
        ops_read_s ##1 jabber_idle_s |=> !remote_jabber_q;
    endproperty

    read_clears_jab_a: assert property (read_clears_p) // [R1]
        else $error("remote jabber not cleared by read");

    jabber_sets_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R2]
        rx_jabber_i |=> remote_jabber_q ##1 (rdata_o[15] || !$past(ops_rd)))
        else $error("remote jabber did not set");

    pol_latch_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R3]
        (pol_rev_q && !ops_rd) |=> pol_rev_q)
        else $error("polarity flag dropped without read");

    set_beats_clr_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
        (ops_rd && rx_pol_reversed_i) |=> pol_rev_q)
        else $error("polarity event lost at clear");

    jabber_ctrl_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R6]
        (ops_wr && !wdata_i[5]) |=> ##1 jabber_check_en_o)
        else $error("jabber check not enabled");

    autopol_ctrl_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R7]
        (ops_wr && wdata_i[3]) |=> ##1 !pol_correct_en_o)
        else $error("polarity correction not suppressed");

    sqe_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R10]
        ($fell(tx_en_i) && sqe_allowed && sqe_q == tenbase_ops_pkg::SQE_IDLE
         && !full_duplex_i ##1 (!tx_en_i && sqe_allowed)[*8])
        |-> ##[1:200] sqe_col_o)
        else $error("no SQE pulse after transmit");

    sqe_auto_inh_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R11]
        (full_duplex_i || repeater_mode_i) |=> !$rose(sqe_col_o))
        else $error("SQE pulse while auto inhibited");

    sqe_bit_kept_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
        !ops_wr |=> ops_q[2] == $past(ops_q[2]))
        else $error("SQE inhibit bit changed without write");

    link_force_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R13]
        (ops_wr && wdata_i[1]) |=> ##1 link_force_pass_o)
        else $error("link not forced passed");

    mirror_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R15]
        (rd_i && addr_i == tenbase_ops_pkg::IDX_EXT_STATUS_MIRROR)
        |=> rdata_o[2:0] == $past(basic_status_i))
        else $error("mirror bits differ from basic status");

    // =========================================================================
    // Further checks on flags, controls and bus
    // =========================================================================
    // Checked on the first edge out of reset, before any request can land
    reset_state_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R1]
        $past(srst_i)
        |-> ops_q == tenbase_ops_pkg::OPS_RESET && !remote_jabber_q && !pol_rev_q)
        else $error("state not at reset value after reset");

    jab_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
        (remote_jabber_q && !ops_rd)
        |=> remote_jabber_q)
        else $error("remote jabber dropped without read");

    jab_beats_clr_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
        (ops_rd && rx_jabber_i)
        |=> remote_jabber_q)
        else $error("jabber event lost at clear");

    pol_sets_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R3]
        rx_pol_reversed_i
        |=> pol_rev_q)
        else $error("polarity flag did not set");

    pol_read_clr_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
        (ops_rd && !rx_pol_reversed_i)
        |=> !pol_rev_q)
        else $error("polarity flag not cleared by read");

    ro_bits_clear_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R3]
        ops_wr
        |=> ops_q[15:14] == 2'b00)
        else $error("read-only bits were stored");

    ops_readback_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
        ops_rd
        |=> rdata_o[13:0] == $past(ops_q[13:0]))
        else $error("control bits read back wrong");

    rdata_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !rd_i
        |=> rdata_o == 16'h0000)
        else $error("read data present without read");

    jabber_follow_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R6]
        1'b1
        |=> jabber_check_en_o == !$past(ops_q[tenbase_ops_pkg::OPS_JABBER_INH]))
        else $error("jabber check enable out of step");

    pol_follow_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R7] [R8]
        1'b1
        |=> pol_correct_en_o == !$past(ops_q[tenbase_ops_pkg::OPS_AUTOPOL_INH]))
        else $error("polarity correction enable out of step");

    link_follow_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R13]
        1'b1
        |=> link_force_pass_o == $past(ops_q[tenbase_ops_pkg::OPS_LINKLOSS_INH]))
        else $error("link force out of step");

    squelch_ctrl_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R14]
        1'b1
        |=> squelch_need_idle_o == $past(ops_q[tenbase_ops_pkg::OPS_SQUELCH_INH]))
        else $error("squelch control out of step");

    sqe_inh_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R9]
        ops_q[tenbase_ops_pkg::OPS_SQE_INH]
        |=> !$rose(sqe_col_o))
        else $error("SQE pulse while inhibited");

    sqe_width_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R10]
        $rose(sqe_col_o)
        |-> sqe_col_o[*8])
        else $error("SQE pulse too short");

    irq_level_a: assert property (@(posedge clk_i) disable iff (srst_i)
        1'b1
        |=> irq_o == $past(|(irq_stat_q & irq_en_q)))
        else $error("interrupt level out of step");

    irq_set_wins_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
        rx_pol_reversed_i
        |=> irq_stat_q[tenbase_ops_pkg::IRQ_POL_REVERSED])
        else $error("interrupt status event lost");

endmodule
`default_nettype wire

// ---- verification/mgmt_station_model.sv ----
// Station management model that drives the register port of the operations block
`timescale 1ns/10ps
`default_nettype none
module mgmt_station_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [4:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 5'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // =========================================================================
    // Bus cycles
    // =========================================================================
    // Released lines show the inverse of the last value so stale data is not mistaken
    task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
        @(posedge clk_i);
        addr_o <= addr;
        wdata_o <= data;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~addr;
        wdata_o <= ~data;
    endtask

    // Reserved fields always carry their defaults, whatever the caller passes
    task automatic write_ops(input logic [15:0] data);
        write_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, (data & 16'h002F) | 16'h0010);
    endtask

    task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
        @(posedge clk_i);
        addr_o <= addr;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~addr;
        #1;
        data = rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- verification/tenbase_t_operations_register_bench.sv ----
// Self-checking bench for the 10 Mb/s operations register block
`timescale 1ns/10ps
`default_nettype none
module tenbase_t_operations_register_bench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic rx_jab = 1'b0;
    logic rx_pol = 1'b0;
    logic tx_en = 1'b0;
    logic fdx = 1'b0;
    logic rptr = 1'b0;
    tenbase_ops_pkg::basic_status_t bstat = '0;
    tenbase_ops_pkg::ops_ctrl_t ctrl;
    logic jce, pce, lfp, sni, sqe, irq;
    logic [15:0] v;
    int num_errors = 0;
    int cmp_count = 0;
    int dly, wid;
    logic [15:0] row_w [7] = '{16'h0010, 16'h0030, 16'h0018, 16'h0014, 16'h0012, 16'h0011,
        16'h003F};
    logic [3:0] row_e [7] = '{4'hC, 4'h4, 4'h8, 4'hC, 4'hE, 4'hD, 4'h3};
    logic [2:0] inh [3] = '{3'h4, 3'h2, 3'h1};

    always #5 clk_i = ~clk_i;

    mgmt_station_model u_station (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    tenbase_t_operations_register u_tenbase_t_operations_register (.clk_i(clk_i),
        .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rx_jabber_i(rx_jab), .rx_pol_reversed_i(rx_pol), .tx_en_i(tx_en),
        .full_duplex_i(fdx), .repeater_mode_i(rptr), .basic_status_i(bstat), .ctrl_o(ctrl),
        .jabber_check_en_o(jce), .pol_correct_en_o(pce), .link_force_pass_o(lfp),
        .squelch_need_idle_o(sni), .sqe_col_o(sqe), .irq_o(irq));

    // =========================================================================
    // Helpers
    // =========================================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic evt(input logic [1:0] sel);
        @(posedge clk_i);
        {rx_pol, rx_jab} <= sel;
        @(posedge clk_i);
        {rx_pol, rx_jab} <= 2'b00;
    endtask

    // Bounded waits keep a stuck pulse from hanging the run
    task automatic packet();
        @(posedge clk_i);
        tx_en <= 1'b1;
        repeat (5) @(posedge clk_i);
        tx_en <= 1'b0;
        dly = 0;
        wid = 0;
        while (sqe !== 1'b1 && dly < 400) begin
            tick(1);
            dly++;
        end
        while (sqe === 1'b1 && wid < 400) begin
            tick(1);
            wid++;
        end
    endtask

    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================================
    // Tests
    // =========================================================================
    initial begin
        tick(4);
        srst_i <= 1'b0;
        tick(1);
        chk({jce, pce, lfp, sni, irq, 6'h0, ctrl}, 16'hC000, "reset outputs");
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, tenbase_ops_pkg::OPS_RESET, "ops reset");
        for (int i = 0; i < 7; i++) begin
            u_station.write_ops(row_w[i]);
            tick(2);
            chk({12'h0, jce, pce, lfp, sni}, {12'h0, row_e[i]}, "controls");
            chk({11'h0, ctrl}, {11'h0, row_w[i][5], row_w[i][3:0]}, "ctrl struct");
            u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
            chk(v, row_w[i], "ops readback");
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            bstat <= 3'(k);
            u_station.read_reg(tenbase_ops_pkg::IDX_EXT_STATUS_MIRROR, v);
            chk(v & 16'h0007, 16'(k), "mirror");
        end
        u_station.write_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, 16'hC010);
        u_station.write_reg(5'h05, 16'hFFFF);
        u_station.read_reg(5'h05, v);
        chk(v, 16'h0000, "unmapped");
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h0010, "read-only flags");
        u_station.write_reg(tenbase_ops_pkg::IDX_IRQ_ENABLE, 16'h0003);
        evt(2'b01);
        tick(3);
        chk({15'h0, irq}, 16'h0001, "irq raised");
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h8010, "jabber latched");
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h0010, "jabber cleared by read");
        u_station.read_reg(tenbase_ops_pkg::IDX_IRQ_STATUS, v);
        chk(v, 16'h0001, "irq status");
        u_station.write_reg(tenbase_ops_pkg::IDX_IRQ_CLEAR, 16'h0001);
        u_station.write_reg(tenbase_ops_pkg::IDX_IRQ_ENABLE, 16'h0001);
        tick(3);
        chk({15'h0, irq}, 16'h0000, "irq cleared");
        @(posedge clk_i);
        rx_pol <= 1'b1;
        tick(2);
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h4010, "polarity latched");
        @(posedge clk_i);
        rx_pol <= 1'b0;
        tick(2);
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h4010, "set beats clear");
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h0010, "polarity cleared");
        chk({14'h0, pce, irq}, 16'h0002, "masked irq, correction kept");
        u_station.write_reg(tenbase_ops_pkg::IDX_IRQ_CLEAR, 16'h0003);
        evt(2'b01);
        @(posedge clk_i);
        srst_i <= 1'b1;
        tick(2);
        srst_i <= 1'b0;
        u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
        chk(v, 16'h0010, "port reset clears");
        packet();
        chk(16'((dly >= tenbase_ops_pkg::SQE_DELAY_CYC - 1) &&
            (dly <= tenbase_ops_pkg::SQE_DELAY_CYC + 2)), 16'h1, "sqe delay");
        chk(16'(wid), 16'(tenbase_ops_pkg::SQE_WIDTH_CYC), "sqe width");
        for (int i = 0; i < 3; i++) begin
            u_station.write_ops(inh[i][2] ? 16'h0014 : 16'h0010);
            @(posedge clk_i);
            {fdx, rptr} <= inh[i][1:0];
            packet();
            chk(16'(wid), 16'h0000, "sqe suppressed");
            u_station.read_reg(tenbase_ops_pkg::IDX_TEN_MEG_OPS, v);
            chk(v, inh[i][2] ? 16'h0014 : 16'h0010, "sqe inhibit kept");
        end
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
